/* File: hw/timer8_core.sv */
// Behaviour
// - force strobe on B acts only in non-PWM waveform modes
// - force strobe applies a match to output B using current mode
// - forced match sets no flag and never clears the counter
// - force bit is write-only and reads back as zero
// - control B bits 5:4 and mask bits 7:3 read zero
// - select codes 0..5: stop, undivided, /8, /64, /256, /1024
// - code 6 counts pin falling edges, code 7 rising edges
// - pin edges count even while the pin is an output
// - counter register is directly readable and writable
// - counter write suppresses compare match on next tick
// - both compare registers compared continuously, drive flags and outputs
// - mask bit 2 with global enable and flag B requests irq
// - mask bit 1 with global enable and flag A requests irq
// - mask bit 0 with global enable and overflow flag requests irq
// - flag bit 2 set on match with compare B
// - flag bit 1 set on match with compare A
// - flag bit 0 set on overflow, point depends on mode
// - each flag clears when its interrupt vector executes
// - writing one clears a flag, zero leaves it
// - overflow at FF in normal/CLEAR_ON_MATCH_MODE/fast, 00 phase-correct, top in fast-A
// - non-PWM B codes toggle, clear, set; zero leaves the pin
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
module timer8_core
    import timer8_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        extCountPin,
    input  wire logic        globalIrqEn,
    input  wire logic [2:0]  vectorAck,
    output logic             waveOutA,
    output logic             waveOutB,
    output logic             outEnA,
    output logic             outEnB,
    output logic [2:0]       irqRequest
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] timerControlA;
    logic [3:0] timerControlB;
    logic [7:0] timerCountValue;
    logic [7:0] compareValueA;
    logic [7:0] compareValueB;
    logic [2:0] timerIrqMask;
    logic [2:0] timerIrqFlags;
    logic       blockMatch;
    dir_type    countDir;
    logic       tick;
    logic       wrStrobe;
    logic       rdStrobe;
    logic [7:0] regAddr;
    logic [7:0] readByte;

    timer8_ahb_slave busSlave (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hready   (hready),
        .wrStrobe (wrStrobe),
        .rdStrobe (rdStrobe),
        .regAddr  (regAddr)
    );

    timer8_tick_select tickSel (
        .clk          (clk),
        .rst_n        (rst_n),
        .clkEn        (clkEn),
        .clkSourceSel (timerControlB[2:0]),
        .extCountPin  (extCountPin),
        .tick         (tick)
    );

    // ************************************************************
    // decode
    // ************************************************************
    wire [7:0] wdata      = hwdata[7:0];
    wire       wrControlA = wrStrobe & (regAddr == ADDR_CONTROL_A);
    wire       wrControlB = wrStrobe & (regAddr == ADDR_CONTROL_B);
    wire       wrCount    = wrStrobe & (regAddr == ADDR_COUNT);
    wire       wrCompareA = wrStrobe & (regAddr == ADDR_COMPARE_A);
    wire       wrCompareB = wrStrobe & (regAddr == ADDR_COMPARE_B);
    wire       wrMask     = wrStrobe & (regAddr == ADDR_IRQ_MASK);
    wire       wrFlags    = wrStrobe & (regAddr == ADDR_IRQ_FLAGS);

    wire [2:0] waveMode   = {timerControlB[POS_WAVE_HIGH], timerControlA[1:0]};
    wire [1:0] outModeA   = timerControlA[POS_OUT_MODE_A +: 2];
    wire [1:0] outModeB   = timerControlA[POS_OUT_MODE_B +: 2];
    wire       nonPwm     = (waveMode == WM_NORMAL) | (waveMode == WM_CTC);
    wire       phaseMode  = (waveMode == WM_PC_FULL) | (waveMode == WM_PC_TOPA);
    wire       topIsA     = (waveMode == WM_CTC) | (waveMode == WM_PC_TOPA)
                          | (waveMode == WM_FAST_TOPA);
    wire [7:0] topValue   = topIsA ? compareValueA : COUNT_MAX;
    wire       atTop      = (timerCountValue == topValue);

    // ************************************************************
    // compare and overflow events
    // ************************************************************
    // a counter write blocks the compare on the following tick
    wire matchA   = tick & ~blockMatch & (timerCountValue == compareValueA);
    wire matchB   = tick & ~blockMatch & (timerCountValue == compareValueB);
    wire overflow = tick & (phaseMode ? (timerCountValue == COUNT_BOTTOM)
                    : (waveMode == WM_FAST_TOPA) ? atTop
                    : (timerCountValue == COUNT_MAX));

    // forced match only in non-PWM, no flag, no counter clear
    wire forceB = wrControlB & wdata[POS_FORCE_B] & nonPwm;

    // ************************************************************
    // counter sequence
    // ************************************************************
    wire       pcTurnDown = (countDir == COUNT_UP) & atTop;
    wire       pcTurnUp   = (countDir == COUNT_DOWN) & (timerCountValue == COUNT_BOTTOM);
    wire       goingDown  = pcTurnDown | ((countDir == COUNT_DOWN) & ~pcTurnUp);
    wire [7:0] next_count = phaseMode ? (goingDown ? timerCountValue - 8'h01
                                                   : timerCountValue + 8'h01)
                          : (atTop & topIsA) ? COUNT_BOTTOM
                          : timerCountValue + 8'h01;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            timerCountValue <= RESET_BYTE;
            countDir        <= COUNT_UP;
            blockMatch      <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wrCount)
                timerCountValue <= wdata;
            else if (tick)
                timerCountValue <= next_count;
            if (tick & phaseMode)
                countDir <= goingDown ? COUNT_DOWN : COUNT_UP;
            else if (tick)
                countDir <= COUNT_UP;
            blockMatch <= wrCount | (blockMatch & ~tick);
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            timerControlA <= RESET_BYTE;
            timerControlB <= 4'h0;
            compareValueA <= RESET_BYTE;
            compareValueB <= RESET_BYTE;
            timerIrqMask  <= 3'h0;
        end
        else if (clkEn)
        begin
            if (wrControlA)
                timerControlA <= wdata & MASK_CONTROL_A;
            if (wrControlB)
                timerControlB <= wdata[3:0];
            if (wrCompareA)
                compareValueA <= wdata;
            if (wrCompareB)
                compareValueB <= wdata;
            if (wrMask)
                timerIrqMask <= wdata[2:0] & MASK_IRQ;
        end
    end

    // ************************************************************
    // interrupt flags
    // ************************************************************
    // a hardware set in the same cycle as a clear wins, so no event is lost
    wire [2:0] setFlags   = {matchB, matchA, overflow};
    wire [2:0] clearFlags = (wrFlags ? wdata[2:0] : 3'h0) | vectorAck;
    wire [2:0] next_flags = setFlags | (timerIrqFlags & ~clearFlags);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timerIrqFlags <= 3'h0;
        else if (clkEn)
            timerIrqFlags <= next_flags;
    end

    assign irqRequest = timerIrqFlags & timerIrqMask & {3{globalIrqEn}};

    // ************************************************************
    // waveform outputs
    // ************************************************************
    function automatic logic applyMode(input logic [1:0] mode, input logic cur);
        case (mode)
            OM_TOGGLE: applyMode = ~cur;
            OM_CLEAR:  applyMode = 1'b0;
            OM_SET:    applyMode = 1'b1;
            default:   applyMode = cur;
        endcase
    endfunction

    // pwm modes: clear/set on match, restore at top (fast) or on the way down
    function automatic logic pwmMode(input logic [1:0] mode, input logic cur,
                                     input logic hit, input logic top, input logic down);
        logic lvl;
        lvl = (mode == OM_SET);
        if (mode[1] & hit)
            pwmMode = down ? ~lvl : lvl;
        else if (mode[1] & top & ~phaseMode)
            pwmMode = ~lvl;
        else
            pwmMode = cur;
    endfunction

    wire down = (countDir == COUNT_DOWN);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            waveOutA <= 1'b0;
            waveOutB <= 1'b0;
        end
        else if (clkEn)
        begin
            if (nonPwm & matchA)
                waveOutA <= applyMode(outModeA, waveOutA);
            else if (~nonPwm & tick)
                waveOutA <= pwmMode(outModeA, waveOutA, matchA, atTop, down);
            if (forceB | (nonPwm & matchB))
                waveOutB <= applyMode(outModeB, waveOutB);
            else if (~nonPwm & tick)
                waveOutB <= pwmMode(outModeB, waveOutB, matchB, atTop, down);
        end
    end

    assign outEnA = (outModeA != OM_OFF);
    assign outEnB = (outModeB != OM_OFF);

    // ************************************************************
    // read path
    // ************************************************************
    // force bit and reserved bits are never stored, so they read zero
    wire [7:0] rdControlB = {4'h0, timerControlB};
    wire [7:0] rdMask     = {5'h00, timerIrqMask};
    wire [7:0] rdFlags    = {5'h00, timerIrqFlags};

    always_comb
    begin
        if (regAddr == ADDR_CONTROL_A)
            readByte = timerControlA;
        else if (regAddr == ADDR_CONTROL_B)
            readByte = rdControlB;
        else if (regAddr == ADDR_COUNT)
            readByte = timerCountValue;
        else if (regAddr == ADDR_COMPARE_A)
            readByte = compareValueA;
        else if (regAddr == ADDR_COMPARE_B)
            readByte = compareValueB;
        else if (regAddr == ADDR_IRQ_MASK)
            readByte = rdMask;
        else if (regAddr == ADDR_IRQ_FLAGS)
            readByte = rdFlags;
        else
            readByte = RESET_BYTE;
    end

    // read data registered on the address phase so it stands in the data phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (clkEn & rdStrobe)
            hrdata <= {24'h00_0000, readByte};
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ************************************************************
    // checks
    // ************************************************************
    force_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & wrControlB & ~nonPwm & ~tick) |=> $stable(waveOutB))
        else $error("force strobe acted in pwm mode");
    force_no_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & forceB & ~tick & ~timerIrqFlags[2] & ~vectorAck[2]) |=> ~timerIrqFlags[2])
        else $error("force strobe set a flag");
    force_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & forceB & outModeB == OM_TOGGLE) |=> (waveOutB != $past(waveOutB)))
        else $error("forced toggle missed");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rdStrobe & ((regAddr == ADDR_CONTROL_B) | (regAddr == ADDR_IRQ_MASK)))
        |=> (hrdata[7:4] == 4'h0) && (!hrdata[3] || $past(regAddr) == ADDR_CONTROL_B))
        else $error("reserved bits nonzero");
    stopped_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (timerControlB[2:0] == CS_STOP & ~wrCount) |=> $stable(timerCountValue))
        else $error("stopped counter moved");
    count_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrCount) |=> timerCountValue == $past(wdata))
        else $error("counter write lost");
    match_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & wrCount) |=> (~matchA & ~matchB))
        else $error("match after counter write");
    flag_b_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & matchB) |=> timerIrqFlags[2])
        else $error("flag b not set");
    flag_a_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & matchA) |=> timerIrqFlags[1])
        else $error("flag a not set");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & wrFlags & wdata[0] & ~overflow) |=> ~timerIrqFlags[0])
        else $error("flag clear failed");
    vector_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn & vectorAck[1] & ~matchA) |=> ~timerIrqFlags[1])
        else $error("vector clear failed");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        irqRequest[2] == (timerIrqFlags[2] & timerIrqMask[2] & globalIrqEn))
        else $error("irq b gating wrong");

    force_cov: cover property (@(posedge clk) disable iff (!rst_n) forceB);
    overflow_cov: cover property (@(posedge clk) disable iff (!rst_n) overflow);
    match_cov: cover property (@(posedge clk) disable iff (!rst_n) matchB ##[1:300] matchA);

endmodule

/* File: hw/timer8_pkg.sv */
package timer8_pkg;

    // ************************************************************
    // register byte addresses on the bus
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL_A   = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_B   = 8'h04;
    localparam logic [7:0] ADDR_COUNT       = 8'h08;
    localparam logic [7:0] ADDR_COMPARE_A   = 8'h0C;
    localparam logic [7:0] ADDR_COMPARE_B   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ACK     = 8'h1C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_FORCE_B       = 6;
    localparam int POS_WAVE_HIGH     = 3;
    localparam int POS_OUT_MODE_B    = 4;
    localparam int POS_OUT_MODE_A    = 6;
    localparam int POS_FLAG_MATCH_B  = 2;
    localparam int POS_FLAG_MATCH_A  = 1;
    localparam int POS_FLAG_OVERFLOW = 0;

    // ************************************************************
    // reset values and read masks
    // ************************************************************
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [7:0] MASK_CONTROL_B  = 8'h0F;
    localparam logic [7:0] MASK_CONTROL_A  = 8'hF3;
    localparam logic [2:0] MASK_IRQ        = 3'h7;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM    = 8'h00;

    // ************************************************************
    // clock select codes and prescale ratios
    // ************************************************************
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIV1      = 3'h1;
    localparam logic [2:0] CS_DIV8      = 3'h2;
    localparam logic [2:0] CS_DIV64     = 3'h3;
    localparam logic [2:0] CS_DIV256    = 3'h4;
    localparam logic [2:0] CS_DIV1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;
    localparam int         PRESCALE_W   = 10;

    // ************************************************************
    // waveform modes
    // ************************************************************
    localparam logic [2:0] WM_NORMAL    = 3'h0;
    localparam logic [2:0] WM_PC_FULL   = 3'h1;
    localparam logic [2:0] WM_CTC       = 3'h2;
    localparam logic [2:0] WM_FAST_FULL = 3'h3;
    localparam logic [2:0] WM_PC_TOPA   = 3'h5;
    localparam logic [2:0] WM_FAST_TOPA = 3'h7;

    // ************************************************************
    // output mode codes
    // ************************************************************
    localparam logic [1:0] OM_OFF    = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic { COUNT_UP, COUNT_DOWN } dir_type;

endpackage

/* File: hw/timer8_tick_select.sv */
module timer8_tick_select
    import timer8_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic [2:0] clkSourceSel,
    input  wire logic       extCountPin,
    output logic            tick
);

    logic [PRESCALE_W-1:0] prescale;
    logic                  pinMeta;
    logic                  pinSync;
    logic                  pinLast;
    wire                   extRise;
    wire                   extFall;

    // ************************************************************
    // free running prescaler and pin synchroniser
    // ************************************************************
    // prescaler shared by all divided taps so ratios stay phase-aligned
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prescale <= '0;
            pinMeta  <= 1'b0;
            pinSync  <= 1'b0;
            pinLast  <= 1'b0;
        end
        else if (clkEn)
        begin
            prescale <= prescale + 1'b1;
            pinMeta  <= extCountPin;
            pinSync  <= pinMeta;
            pinLast  <= pinSync;
        end
    end

    // pin edges count even when the pin is driven as an output
    assign extRise = pinSync & ~pinLast;
    assign extFall = ~pinSync & pinLast;

    // ************************************************************
    // clock source decode
    // ************************************************************
    wire tapDiv8    = (prescale[2:0] == 3'h7);
    wire tapDiv64   = (prescale[5:0] == 6'h3F);
    wire tapDiv256  = (prescale[7:0] == 8'hFF);
    wire tapDiv1024 = (prescale == 10'h3FF);

    assign tick = clkEn & (
                  (clkSourceSel == CS_DIV1)
                | (clkSourceSel == CS_DIV8     & tapDiv8)
                | (clkSourceSel == CS_DIV64    & tapDiv64)
                | (clkSourceSel == CS_DIV256   & tapDiv256)
                | (clkSourceSel == CS_DIV1024  & tapDiv1024)
                | (clkSourceSel == CS_EXT_FALL & extFall)
                | (clkSourceSel == CS_EXT_RISE & extRise));

endmodule

/* File: hw/timer8_ahb_slave.sv */
module timer8_ahb_slave
    import timer8_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             wrStrobe,
    output logic             rdStrobe,
    output logic [7:0]       regAddr
);

    logic       pendWrite;
    logic [7:0] pendAddr;

    // ************************************************************
    // address phase capture
    // ************************************************************
    wire take = clkEn & hsel & hready & (htrans == HTRANS_NONSEQ);

    // writes land in the data phase, when hwdata is valid
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pendWrite <= 1'b0;
            pendAddr  <= RESET_BYTE;
        end
        else if (clkEn)
        begin
            pendWrite <= take & hwrite;
            pendAddr  <= take ? haddr : pendAddr;
        end
    end

    assign wrStrobe = pendWrite & clkEn;
    assign rdStrobe = take & ~hwrite;
    assign regAddr  = pendWrite ? pendAddr : haddr;

endmodule

/* File: tb/cpu_irq_model.sv */
module cpu_irq_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ackOn,
    input  wire logic [2:0] irqRequest,
    output logic [2:0]      vectorAck
);
    timeunit 1ns;
    timeprecision 1ps;
    // vector executes one cycle after a request; a single pulse so a new flag is not eaten
    always_ff @(posedge clk)
    begin
        if (!rst_n || vectorAck != 3'h0)
            vectorAck <= 3'h0;
        else
            vectorAck <= irqRequest & {3{ackOn}};
    end
endmodule

/* File: tb/timer8_core_tb.sv */
module timer8_core_tb
    import timer8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, hsel, hwrite, extCountPin, globalIrqEn, ackOn, hreadyout, hresp;
    logic        waveOutA, waveOutB, outEnA, outEnB, b;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, r;
    logic [2:0]  vectorAck, irqRequest;
    int          n_mismatch, checks, cyc, seed, mdl[int];
    timer8_core dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extCountPin(extCountPin),
        .globalIrqEn(globalIrqEn), .vectorAck(vectorAck), .waveOutA(waveOutA),
        .waveOutB(waveOutB), .outEnA(outEnA), .outEnB(outEnB), .irqRequest(irqRequest));
    cpu_irq_model cpu (.clk(clk), .rst_n(rst_n), .ackOn(ackOn), .irqRequest(irqRequest),
        .vectorAck(vectorAck));
    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a hung wait counts as a mismatch and closes the run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end
    function automatic int rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed & 32'hFF;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single AHB transfer; the model mirrors what the control B, mask, count and compare bytes keep
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
        if (w)
            mdl[a] = d & (a == ADDR_CONTROL_B ? MASK_CONTROL_B
                        : a == ADDR_IRQ_MASK ? {5'h00, MASK_IRQ} : 8'hFF);
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        extCountPin = 1'b0;
        globalIrqEn = 1'b0;
        ackOn = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        seed = 76941;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        xfer(1, ADDR_CONTROL_B, 32'hFF);
        xfer(0, ADDR_CONTROL_B, 0);
        chk(r, mdl[ADDR_CONTROL_B]);
        xfer(1, ADDR_IRQ_MASK, 32'hFF);
        xfer(0, ADDR_IRQ_MASK, 0);
        chk(r, mdl[ADDR_IRQ_MASK]);
        xfer(1, ADDR_CONTROL_B, 0);
        xfer(0, 8'h40, 0);
        chk(r, 0);
        chk(hresp, 0);
        // random bytes through count and compare registers while the counter is stopped
        for (int i = 0; i < 6; i++)
        begin
            haddr <= i % 3 == 0 ? ADDR_COUNT : i % 3 == 1 ? ADDR_COMPARE_A : ADDR_COMPARE_B;
            @(posedge clk);
            xfer(1, haddr, rnd());
            repeat (20) @(posedge clk);
            xfer(0, haddr, 0);
            chk(r, mdl[haddr]);
        end
        xfer(1, ADDR_COUNT, 0);
        xfer(1, ADDR_COMPARE_A, 8);
        xfer(1, ADDR_COMPARE_B, 5);
        xfer(1, ADDR_IRQ_FLAGS, 7);
        xfer(1, ADDR_CONTROL_B, CS_DIV1);
        repeat (30) @(posedge clk);
        xfer(1, ADDR_CONTROL_B, 0);
        xfer(0, ADDR_IRQ_FLAGS, 0);
        chk(r, 6);
        globalIrqEn <= 1'b1;
        @(posedge clk);
        chk(irqRequest, 6);
        xfer(1, ADDR_IRQ_FLAGS, 2);
        xfer(0, ADDR_IRQ_FLAGS, 0);
        chk(r, 4);
        // wrap through overflow with output A toggling once on its match
        xfer(1, ADDR_IRQ_MASK, 1);
        xfer(1, ADDR_CONTROL_A, 32'h40);
        xfer(1, ADDR_COUNT, 8'hF0);
        xfer(1, ADDR_CONTROL_B, CS_DIV1);
        repeat (40) @(posedge clk);
        xfer(1, ADDR_CONTROL_B, 0);
        xfer(0, ADDR_IRQ_FLAGS, 0);
        chk(r, 7);
        chk(irqRequest, 1);
        chk(waveOutA, 1);
        chk(outEnA, 1);
        // vectors for overflow and match A run, flag B stays
        xfer(1, ADDR_IRQ_MASK, 3);
        ackOn <= 1'b1;
        repeat (3) @(posedge clk);
        ackOn <= 1'b0;
        xfer(0, ADDR_IRQ_FLAGS, 0);
        chk(r, 4);
        // external pin, falling then rising edge selection
        for (int c = 6; c < 8; c++)
        begin
            xfer(1, ADDR_COUNT, 0);
            xfer(1, ADDR_CONTROL_B, c);
            repeat (5)
            begin
                extCountPin <= 1'b1;
                repeat (8) @(posedge clk);
                extCountPin <= 1'b0;
                repeat (8) @(posedge clk);
            end
            xfer(1, ADDR_CONTROL_B, 0);
            xfer(0, ADDR_COUNT, 0);
            chk(r, 5);
        end
        // forced match in normal mode applies out mode B, in fast PWM it is ignored
        xfer(1, ADDR_CONTROL_A, 32'h10);
        xfer(1, ADDR_IRQ_FLAGS, 7);
        b = waveOutB;
        xfer(1, ADDR_CONTROL_B, 32'h40);
        repeat (2) @(posedge clk);
        chk(waveOutB, {31'h0, ~b});
        chk(outEnB, 1);
        xfer(0, ADDR_IRQ_FLAGS, 0);
        chk(r, 0);
        xfer(0, ADDR_COUNT, 0);
        chk(r, 5);
        xfer(1, ADDR_CONTROL_A, 32'h20);
        xfer(1, ADDR_CONTROL_B, 32'h40);
        @(posedge clk);
        chk(waveOutB, 0);
        xfer(1, ADDR_CONTROL_A, 32'h30);
        xfer(1, ADDR_CONTROL_B, 32'h40);
        @(posedge clk);
        chk(waveOutB, 1);
        xfer(1, ADDR_CONTROL_A, 32'h13);
        b = waveOutB;
        xfer(1, ADDR_CONTROL_B, 32'h40);
        repeat (2) @(posedge clk);
        chk(waveOutB, b);
        // ordinary software write in a pwm mode keeps the force bit low
        xfer(1, ADDR_CONTROL_B, 0);
        chk(waveOutB, b);
        test_done();
    end
endmodule
